// ===== inc/tsc_pkg.sv
// Constants and types of the transmit-state controller
// Contract
// R1: Four working states, sleep, oscillator startup, tune, transmit, in that order.
// R2: In sleep every internal block stays powered down until a start event.
// R3: Configured start edge, rising or falling, leaves sleep for oscillator startup.
// R4: Host waits about 400 us oscillator settle after the start edge.
// R5: Tune lasts about 370 us; no amplifier or data before it completes.
// R6: In transmit the data pin level is passed on to the amplifier.
// R7: Data pin low for the configured stop time ends transmission, back to sleep.
// R8: Stop time codes give 2 to 9 ms and 20 to 90 ms.
// R9: Software reset command ends an ongoing transmission within 1 ms.
// R10: Rising start: host holds the pin high at least 10 ns.
// R11: Rising start: pin level ignored until tuning ends; host delays useful data.
// R12: Falling start: host holds the pin low during oscillator startup.
// R13: Falling start: settle leads to tune; pin level ignored while tuning.
// R14: Falling start: host returns the pin high before the next start edge.
// R15: Ramp time codes give 0 and 1 to 1024 us in powers of two.
// R16: Ramp code zero brings amplifier to full power at once.
// R17: Ramp down takes as long as ramp up for every setting.
// R18: Host keeps ramp time at most half the inverse of max_symbol_rate.
// R19: Output power codes span -10 to +13 dBm in 1 dB steps.
// R20: With an external reference the load capacitance is set to minimum.
// R21: Software reset is the 16-bit word BD01; host then waits 1 ms.
// R22: Two-wire data changes on rising clock, device samples on falling clock.
// R23: Any high level on the pin restarts the stop-low timer.
package tsc_pkg;
    localparam int CLK_MHZ = 200;
    localparam int US_PER_MS = 1000;
    localparam int OSC_SETTLE_US = 400;
    localparam int TUNE_US = 370;
    localparam int OSC_CYCLES = OSC_SETTLE_US * CLK_MHZ;
    localparam int TUNE_CYCLES = TUNE_US * CLK_MHZ;
    localparam int MS_CYCLES = US_PER_MS * CLK_MHZ;
    localparam int US_CYCLES = CLK_MHZ;
    localparam int CNT_W = 18;

    localparam int STOP_SEL_W = 4;
    localparam int STOP_MS_W = 7;
    localparam int STOP_FINE_CODES = 8;
    localparam int STOP_FINE_MIN_MS = 2;
    localparam int STOP_FINE_STEP_MS = 1;
    localparam int STOP_COARSE_MIN_MS = 20;
    localparam int STOP_COARSE_STEP_MS = 10;

    localparam int RAMP_SEL_W = 4;
    localparam int RAMP_SEL_MAX = 11;
    localparam int GAIN_W = 11;
    localparam int RAMP_FULL = 1024;

    localparam int PWR_CODE_W = 5;
    localparam int PWR_CODE_MAX = 23;
    localparam int PWR_MIN_DBM = -10;

    localparam int TWI_CMD_BITS = 16;
    localparam logic [15:0] SOFT_RST_CMD = 16'hbd01;

    localparam int FIFO_DEPTH = 32;
    localparam int SAMPLE_W = 1;

    typedef enum logic [1:0] {
        sleep_state,
        osc_startup_state,
        tune_state,
        transmit_state
    } tsc_state_t;
endpackage : tsc_pkg

// ===== src/tsc_fifo.sv
// Sample FIFO between the data pin and the modulator
`timescale 1ns/1ps
module tsc_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 32
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic do_wr, do_rd;

    // Extra pointer bit tells full from empty
    assign in_ready_out = !((wr_ptr[AW] != rd_ptr[AW]) &&
                            (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid_out = (wr_ptr != rd_ptr);
    assign out_data_out = mem[rd_ptr[AW-1:0]];
    assign do_wr = in_valid_in && in_ready_out && !flush_in;
    assign do_rd = out_valid_out && out_ready_in && !flush_in;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (flush_in) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
        end else begin
            if (do_wr) next_wr_ptr = wr_ptr + 1'b1;
            if (do_rd) next_rd_ptr = rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    // Storage needs no reset; reads are guarded by the pointers
    always_ff @(posedge core_clk_in) begin
        if (do_wr) mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
endmodule : tsc_fifo

// ===== src/tsc_ramp.sv
// Power amplifier gain ramp, up and down at one rate
`timescale 1ns/1ps
module tsc_ramp #(
    parameter int US_CYC = tsc_pkg::US_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic up_in,
    input wire logic kill_in,
    input wire logic [tsc_pkg::RAMP_SEL_W-1:0] sel_in,
    output logic [tsc_pkg::GAIN_W-1:0] gain_out,
    output logic zero_out
);
    localparam int GW = tsc_pkg::GAIN_W;
    localparam logic [GW-1:0] FULL = GW'(tsc_pkg::RAMP_FULL);
    localparam logic [7:0] US_LAST = 8'(US_CYC - 1);
    localparam logic [3:0] SEL_MAX = 4'(tsc_pkg::RAMP_SEL_MAX);
    logic [7:0] pre, next_pre;
    logic [GW-1:0] next_gain;
    logic [GW-1:0] step;
    logic [GW:0] sum;
    logic [3:0] sel;
    logic tick;

    assign tick = (pre == US_LAST);
    assign sel = (sel_in > SEL_MAX) ? SEL_MAX : sel_in;
    // Code k moves 1/2^(k-1) of full scale per microsecond
    assign step = FULL >> (sel - 4'h1);
    assign zero_out = (gain_out == '0);

    always_comb begin
        next_pre = tick ? 8'h00 : pre + 8'h01;
        next_gain = gain_out;
        sum = '0;
        if (kill_in) begin
            next_gain = '0;
        end else if (sel == 4'h0) begin
            next_gain = up_in ? FULL : '0; // R16
        end else if (tick && up_in) begin
            sum = {1'b0, gain_out} + {1'b0, step}; // R15
            next_gain = (sum > {1'b0, FULL}) ? FULL : sum[GW-1:0];
        end else if (tick) begin
            // Same step downward keeps both ramps equally long
            next_gain = (gain_out > step) ? gain_out - step : '0; // R17
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pre <= '0;
            gain_out <= '0;
        end else begin
            pre <= next_pre;
            gain_out <= next_gain;
        end
    end

    ramp_zero_a: assert property (@(posedge core_clk_in) // R16
        disable iff (!arst_n_in) (sel == 4'h0 && up_in && !kill_in)
        |=> gain_out == FULL)
        else $error("zero ramp code did not reach full gain");

    ramp_step_a: assert property (@(posedge core_clk_in) // R17
        disable iff (!arst_n_in)
        (tick && !kill_in && sel != 4'h0 && !up_in && gain_out >= step)
        |=> gain_out == $past(gain_out) - $past(step))
        else $error("ramp down step differs from ramp up step");
endmodule : tsc_ramp

// ===== src/tsc_top.sv
// Transmit-state controller: sequencing, stop timer, command decode
`timescale 1ns/1ps
module tsc_top #(
    parameter int OSC_CYC = tsc_pkg::OSC_CYCLES,
    parameter int TUNE_CYC = tsc_pkg::TUNE_CYCLES,
    parameter int MS_CYC = tsc_pkg::MS_CYCLES,
    parameter int DEPTH = tsc_pkg::FIFO_DEPTH
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic data_pin_in,
    input wire logic start_falling_in,
    input wire logic [tsc_pkg::STOP_SEL_W-1:0] stop_sel_in,
    input wire logic [tsc_pkg::RAMP_SEL_W-1:0] ramp_sel_in,
    input wire logic [tsc_pkg::PWR_CODE_W-1:0] power_code_in,
    input wire logic twi_clk_in,
    input wire logic twi_data_in,
    input wire logic mod_ready_in,
    output logic [1:0] state_out,
    output logic osc_en_out,
    output logic synth_en_out,
    output logic power_amplifier_en_out,
    output logic [tsc_pkg::GAIN_W-1:0] power_amplifier_gain_out,
    output logic [tsc_pkg::PWR_CODE_W-1:0] power_amplifier_code_out,
    output logic tx_data_out,
    output logic tx_valid_out,
    output logic sample_ready_out
);
    localparam int CW = tsc_pkg::CNT_W;
    localparam int MW = tsc_pkg::STOP_MS_W;
    localparam int PW = tsc_pkg::PWR_CODE_W;
    localparam logic [CW-1:0] OSC_LAST = CW'(OSC_CYC - 1);
    localparam logic [CW-1:0] TUNE_LAST = CW'(TUNE_CYC - 1);
    localparam logic [CW-1:0] MS_LAST = CW'(MS_CYC - 1);
    localparam logic [PW-1:0] PWR_MAX = PW'(tsc_pkg::PWR_CODE_MAX);
    localparam logic [3:0] FINE_CODES = 4'(tsc_pkg::STOP_FINE_CODES);
    localparam logic [MW-1:0] FINE_MIN = MW'(tsc_pkg::STOP_FINE_MIN_MS);
    localparam logic [MW-1:0] FINE_STEP = MW'(tsc_pkg::STOP_FINE_STEP_MS);
    localparam logic [MW-1:0] CRS_MIN = MW'(tsc_pkg::STOP_COARSE_MIN_MS);
    localparam logic [MW-1:0] CRS_STEP = MW'(tsc_pkg::STOP_COARSE_STEP_MS);
    localparam logic [15:0] CMD = tsc_pkg::SOFT_RST_CMD;

    tsc_pkg::tsc_state_t state, next_state;
    logic [CW-1:0] cnt, next_cnt;
    logic [MW-1:0] ms_cnt, next_ms_cnt;
    logic stopping, next_stopping;
    logic armed, data_q, twi_clk_q;
    logic [15:0] twi_sh, next_twi_sh;
    logic [PW-1:0] next_power;
    logic next_tx_data, next_tx_valid;

    logic start_edge, twi_fall, soft_hit, ms_tick;
    logic [MW-1:0] stop_ms;
    logic sending, ramp_zero;
    logic fifo_valid, fifo_data, fifo_pop;

    // Edge detection is disarmed for the first cycle after reset, so a
    // pin already high at release does not count as a rising edge
    always_comb begin
        if (start_falling_in) begin
            start_edge = armed && data_q && !data_pin_in; // R3
        end else begin
            start_edge = armed && !data_q && data_pin_in; // R3
        end
    end

    // Device samples the two-wire data line on the falling clock edge
    assign twi_fall = twi_clk_q && !twi_clk_in; // R22
    assign soft_hit = twi_fall && ({twi_sh[14:0], twi_data_in} == CMD); // R21

    always_comb begin
        next_twi_sh = twi_sh;
        if (soft_hit) begin
            next_twi_sh = '0;
        end else if (twi_fall) begin
            next_twi_sh = {twi_sh[14:0], twi_data_in}; // R22
        end
    end

    // Stop time code to milliseconds
    always_comb begin
        if (stop_sel_in < FINE_CODES) begin
            stop_ms = FINE_MIN + FINE_STEP * MW'(stop_sel_in); // R8
        end else begin
            stop_ms = CRS_MIN + CRS_STEP * MW'(stop_sel_in - FINE_CODES); // R8
        end
    end

    assign ms_tick = (cnt == MS_LAST);
    assign sending = (state == tsc_pkg::transmit_state) && !stopping;

    // Main sequence: one shared counter times settle, tune and the
    // stop-low prescaler, since only one is needed in each state
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_ms_cnt = ms_cnt;
        next_stopping = stopping;
        case (state)
            tsc_pkg::sleep_state: begin
                next_cnt = '0;
                next_ms_cnt = '0;
                next_stopping = 1'b0;
                if (start_edge) begin
                    next_state = tsc_pkg::osc_startup_state; // R3
                end
            end
            tsc_pkg::osc_startup_state: begin
                // Pin level is not looked at while the oscillator settles
                if (cnt == OSC_LAST) begin
                    next_cnt = '0;
                    next_state = tsc_pkg::tune_state; // R1 R13
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            tsc_pkg::tune_state: begin
                // Pin ignored here; amplifier stays off until done
                if (cnt == TUNE_LAST) begin
                    next_cnt = '0;
                    next_state = tsc_pkg::transmit_state; // R5 R11 R13
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            tsc_pkg::transmit_state: begin
                if (stopping) begin
                    // Stay until the amplifier has ramped down fully
                    if (ramp_zero) begin
                        next_state = tsc_pkg::sleep_state; // R7
                        next_stopping = 1'b0;
                    end
                end else if (data_pin_in) begin
                    next_cnt = '0; // R23
                    next_ms_cnt = '0; // R23
                end else if (ms_tick) begin
                    next_cnt = '0;
                    next_ms_cnt = ms_cnt + 1'b1;
                    if (ms_cnt + 1'b1 >= stop_ms) begin
                        next_stopping = 1'b1; // R7
                    end
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            default: begin
                next_state = tsc_pkg::sleep_state;
            end
        endcase
        // Software reset cuts the amplifier at once, well inside 1 ms,
        // even with the longest ramp selected
        if (soft_hit) begin
            next_state = tsc_pkg::sleep_state; // R9
            next_cnt = '0;
            next_ms_cnt = '0;
            next_stopping = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= tsc_pkg::sleep_state;
            cnt <= '0;
            ms_cnt <= '0;
            stopping <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            ms_cnt <= next_ms_cnt;
            stopping <= next_stopping;
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            armed <= 1'b0;
            data_q <= 1'b0;
            twi_clk_q <= 1'b0;
            twi_sh <= '0;
        end else begin
            armed <= 1'b1;
            data_q <= data_pin_in;
            twi_clk_q <= twi_clk_in;
            twi_sh <= next_twi_sh;
        end
    end

    // Power blocks follow the state; all off in sleep
    assign state_out = state;
    assign osc_en_out = (state != tsc_pkg::sleep_state); // R2
    assign synth_en_out = (state == tsc_pkg::tune_state) ||
                          (state == tsc_pkg::transmit_state); // R2
    assign power_amplifier_en_out = !ramp_zero; // R2 R5

    tsc_ramp #(
        .US_CYC(tsc_pkg::US_CYCLES)
    ) u_ramp (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .up_in(sending),
        .kill_in(soft_hit),
        .sel_in(ramp_sel_in),
        .gain_out(power_amplifier_gain_out),
        .zero_out(ramp_zero)
    );

    // Samples dropped while the FIFO is full show as sample_ready_out low
    tsc_fifo #(
        .WIDTH(tsc_pkg::SAMPLE_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .core_clk_in(core_clk_in),
        .arst_n_in(arst_n_in),
        .flush_in(state == tsc_pkg::sleep_state),
        .in_valid_in(sending),
        .in_ready_out(sample_ready_out),
        .in_data_in(data_pin_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(mod_ready_in),
        .out_data_out(fifo_data)
    );

    // No sample is reported on the edge that ends transmission, so the
    // modulator never sees a pulse while the device is already asleep
    assign fifo_pop = fifo_valid && mod_ready_in &&
                      (state != tsc_pkg::sleep_state) &&
                      (next_state != tsc_pkg::sleep_state);

    always_comb begin
        next_tx_valid = fifo_pop; // R6
        next_tx_data = fifo_pop ? fifo_data : tx_data_out; // R6
        // Codes above the top setting clamp to +13 dBm
        next_power = (power_code_in > PWR_MAX) ? PWR_MAX : power_code_in; // R19
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tx_valid_out <= 1'b0;
            tx_data_out <= 1'b0;
            power_amplifier_code_out <= '0;
        end else begin
            tx_valid_out <= next_tx_valid;
            tx_data_out <= next_tx_data;
            power_amplifier_code_out <= next_power;
        end
    end

    sleep_off_a: assert property (@(posedge core_clk_in) // R2
        disable iff (!arst_n_in) (state == tsc_pkg::sleep_state)
        |-> !osc_en_out && !synth_en_out && power_amplifier_gain_out == '0)
        else $error("block powered while asleep");

    start_edge_a: assert property (@(posedge core_clk_in) // R3
        disable iff (!arst_n_in)
        (state == tsc_pkg::sleep_state && start_edge && !soft_hit)
        |=> state == tsc_pkg::osc_startup_state)
        else $error("start edge did not wake the device");

    settle_time_a: assert property (@(posedge core_clk_in) // R1
        disable iff (!arst_n_in) $rose(state == tsc_pkg::tune_state)
        |-> $past(state) == tsc_pkg::osc_startup_state &&
            $past(cnt) == OSC_LAST)
        else $error("tune entered before oscillator settle");

    tune_time_a: assert property (@(posedge core_clk_in) // R5
        disable iff (!arst_n_in) $rose(state == tsc_pkg::transmit_state)
        |-> $past(state) == tsc_pkg::tune_state &&
            $past(cnt) == TUNE_LAST)
        else $error("transmit entered before tune finished");

    no_amp_early_a: assert property (@(posedge core_clk_in) // R11
        disable iff (!arst_n_in) (state != tsc_pkg::transmit_state)
        |-> !sending && power_amplifier_gain_out == '0 && !tx_valid_out
        ##1 !tx_valid_out)
        else $error("amplifier or data active before transmit");

    tune_ignore_a: assert property (@(posedge core_clk_in) // R13
        disable iff (!arst_n_in)
        (state == tsc_pkg::tune_state && cnt != TUNE_LAST && !soft_hit)
        |=> state == tsc_pkg::tune_state && cnt == $past(cnt) + 1'b1)
        else $error("tune timing disturbed by the data pin");

    pass_data_a: assert property (@(posedge core_clk_in) // R6
        disable iff (!arst_n_in)
        (fifo_pop && !soft_hit) |=> tx_valid_out &&
        tx_data_out == $past(fifo_data))
        else $error("sample not passed to the amplifier");

    stop_time_a: assert property (@(posedge core_clk_in) // R7
        disable iff (!arst_n_in) $rose(stopping)
        |-> $past(ms_cnt) + 1'b1 == $past(stop_ms) && !$past(data_pin_in))
        else $error("stop taken at wrong low time");

    low_restart_a: assert property (@(posedge core_clk_in) // R23
        disable iff (!arst_n_in) (sending && data_pin_in && !soft_hit)
        |=> ms_cnt == '0 && cnt == '0)
        else $error("high level did not restart stop timer");

    soft_reset_a: assert property (@(posedge core_clk_in) // R9
        disable iff (!arst_n_in) soft_hit
        |=> state == tsc_pkg::sleep_state && power_amplifier_gain_out == '0)
        else $error("software reset did not end transmission");

    power_range_a: assert property (@(posedge core_clk_in) // R19
        disable iff (!arst_n_in) 1'b1 |=> power_amplifier_code_out <= PWR_MAX)
        else $error("power code out of range");
endmodule : tsc_top

// ===== verification/tb_top.sv
// Self-checking bench of the transmit-state controller
`timescale 1ns/1ps
module tb_top;
    localparam int OSC = 40;
    localparam int TUNE = 30;
    localparam int MS = 50;
    logic core_clk_in;
    logic arst_n_in;
    logic data_pin, twi_clk, twi_data;
    logic start_falling;
    logic [tsc_pkg::STOP_SEL_W-1:0] stop_sel;
    logic [tsc_pkg::RAMP_SEL_W-1:0] ramp_sel;
    logic [tsc_pkg::PWR_CODE_W-1:0] power_code;
    logic mod_ready;
    logic [1:0] state_out;
    logic osc_en, synth_en, amp_en, tx_data, tx_valid, sample_ready;
    logic [tsc_pkg::GAIN_W-1:0] gain;
    logic [tsc_pkg::PWR_CODE_W-1:0] pwr_out;
    int err_total = 0;
    int n_tests = 0;

    initial begin
        core_clk_in = 1'b0;
        // Stands in for an external reference; no crystal load is set here
        forever #2.5 core_clk_in = ~core_clk_in;
    end

    tsc_host host (.core_clk_in(core_clk_in), .data_pin_out(data_pin),
        .twi_clk_out(twi_clk), .twi_data_out(twi_data));

    tsc_top #(.OSC_CYC(OSC), .TUNE_CYC(TUNE), .MS_CYC(MS)) DUT (
        .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .data_pin_in(data_pin), .start_falling_in(start_falling),
        .stop_sel_in(stop_sel), .ramp_sel_in(ramp_sel),
        .power_code_in(power_code), .twi_clk_in(twi_clk),
        .twi_data_in(twi_data), .mod_ready_in(mod_ready),
        .state_out(state_out), .osc_en_out(osc_en),
        .synth_en_out(synth_en), .power_amplifier_en_out(amp_en),
        .power_amplifier_gain_out(gain),
        .power_amplifier_code_out(pwr_out), .tx_data_out(tx_data),
        .tx_valid_out(tx_valid), .sample_ready_out(sample_ready));

    task automatic step(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : step

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    task automatic wait_state(input logic [1:0] s, input int lim);
        int k;
        k = 0;
        while (state_out !== s && k < lim) begin
            step(1);
            k++;
        end
        check(state_out, s);
    endtask : wait_state

    task automatic t_power();
        int v[4] = '{0, 23, 24, 31};
        foreach (v[i]) begin
            power_code = 5'(v[i]);
            step(2);
            check(pwr_out, (v[i] > tsc_pkg::PWR_CODE_MAX) ?
                tsc_pkg::PWR_CODE_MAX : v[i]);
        end
    endtask : t_power

    task automatic t_start(input logic falling);
        start_falling = falling;
        step(2);
        check(state_out, 2'h0);
        check({osc_en, synth_en, amp_en}, 3'h0);
        host.start_edge(falling);
        step(1);
        check(state_out, 2'h1);
        check(osc_en, 1'b1);
        step(1);
        if (!falling) host.pin(1'b0);
        step(OSC - 4);
        check({state_out, synth_en}, 3'h2);
        wait_state(2'h2, 4);
        host.wiggle(TUNE - 4);
        check({amp_en, tx_valid}, 2'h0);
        check(state_out, 2'h2);
        wait_state(2'h3, 6);
    endtask : t_start

    task automatic t_data();
        host.pin(1'b1);
        step(8);
        check({tx_data, tx_valid}, 2'h3);
        host.pin(1'b0);
        step(8);
        check({tx_data, tx_valid}, 2'h1);
        host.pin(1'b1);
    endtask : t_data

    // A single high cycle near the end must push the stop back in full
    task automatic t_stop(input logic [3:0] code, input int ms);
        stop_sel = code;
        step(2);
        host.pin(1'b0);
        step(ms * MS - 20);
        host.pin(1'b1);
        step(1);
        host.pin(1'b0);
        step(ms * MS - 5);
        check(state_out, 2'h3);
        wait_state(2'h0, 15);
    endtask : t_stop

    task automatic t_ramp();
        int n;
        ramp_sel = 4'h3;
        t_start(1'b0);
        // One high symbol, held only until the selected ramp reaches full gain
        host.pin(1'b1);
        n = 0;
        while (gain === 11'h000 && n < 250) begin
            step(1);
            n++;
        end
        n = 0;
        while (gain !== tsc_pkg::RAMP_FULL && n < 1000) begin
            step(1);
            n++;
        end
        check(n, 3 * tsc_pkg::US_CYCLES);
        check(amp_en, 1'b1);
        stop_sel = 4'h0;
        host.pin(1'b0);
        n = 0;
        while (gain === tsc_pkg::RAMP_FULL && n < 400) begin
            step(1);
            n++;
        end
        n = 0;
        while (gain !== 11'h000 && n < 1000) begin
            step(1);
            n++;
        end
        check(n, 3 * tsc_pkg::US_CYCLES);
        check(amp_en, 1'b0);
        wait_state(2'h0, 5);
        ramp_sel = 4'h0;
    endtask : t_ramp

    task automatic t_soft();
        t_start(1'b0);
        host.pin(1'b1);
        step(1);
        check(gain, tsc_pkg::RAMP_FULL);
        host.send_word(16'hbd00);
        check(state_out, 2'h3);
        host.send_word(tsc_pkg::SOFT_RST_CMD);
        step(1);
        check({state_out, gain}, 13'h0000);
        host.pin(1'b0);
    endtask : t_soft

    task automatic t_fifo();
        int n;
        t_start(1'b0);
        host.pin(1'b1);
        mod_ready = 1'b0;
        step(40);
        check({sample_ready, tx_valid}, 2'h0);
        mod_ready = 1'b1;
        step(1);
        n = 0;
        repeat (40) begin
            step(1);
            n += (tx_valid === 1'b1);
        end
        check(n, 40);
        arst_n_in = 1'b0;
        step(1);
        check({state_out, gain, sample_ready}, 14'h0001);
        arst_n_in = 1'b1;
        step(3);
        host.pin(1'b0);
    endtask : t_fifo

    initial begin
        static logic [3:0] codes[4] = '{4'h0, 4'h7, 4'h8, 4'hf};
        static int ms[4] = '{2, 9, 20, 90};
        arst_n_in = 1'b0;
        start_falling = 1'b0;
        stop_sel = 4'h0;
        ramp_sel = 4'h0;
        power_code = 5'h00;
        mod_ready = 1'b1;
        repeat (6) @(posedge core_clk_in);
        #1;
        arst_n_in = 1'b1;
        step(3);
        t_power();
        for (int i = 0; i < 4; i++) begin
            t_start(1'(i % 2));
            t_data();
            t_stop(codes[i], ms[i]);
        end
        start_falling = 1'b0;
        t_ramp();
        t_soft();
        t_fifo();
        wrap_up();
    end

    // Whole sequence needs well under a third of this span
    initial begin
        repeat (60000) @(posedge core_clk_in);
        err_total++;
        wrap_up();
    end
endmodule : tb_top

// ===== verification/tsc_host.sv
// Host model driving the data pin and the two-wire lines
`timescale 1ns/1ps
module tsc_host (
    input wire logic core_clk_in,
    output logic data_pin_out,
    output logic twi_clk_out,
    output logic twi_data_out
);
    initial begin
        data_pin_out = 1'b0;
        twi_clk_out = 1'b1;
        twi_data_out = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : tick

    task automatic pin(input logic v);
        data_pin_out = v;
    endtask : pin

    // Idle level first, so a falling start always follows a high pin
    task automatic start_edge(input logic falling);
        data_pin_out = falling;
        tick(3);
        data_pin_out = ~falling;
    endtask : start_edge

    // Level is meaningless while tuning, so make it as busy as possible
    task automatic wiggle(input int n);
        repeat (n) begin
            data_pin_out = ~data_pin_out;
            tick(1);
        end
    endtask : wiggle

    // Data moves with the rising clock and is held across the fall
    task automatic send_word(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            twi_data_out = w[i];
            tick(4);
            twi_clk_out = 1'b0;
            tick(4);
            twi_clk_out = 1'b1;
        end
        // Released line shows no stale bit; clock rests high. One idle
        // cycle keeps a following word from moving the line twice at once
        twi_data_out = ~w[0];
        tick(1);
    endtask : send_word
endmodule : tsc_host
